// [ssc_top.sv]
// Serial port status/control register, buffers and serial shifter
`timescale 1ns/100ps
module ssc_top #(
  parameter int DEPTH = 8,
  parameter int CLK_DIV = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic idle_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  output ssc_pkg::ssc_pins_type pins_o,
  output logic pins_oe_o,
  output logic irq_o
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);
  // Saturating level to three-bit count field
  function automatic logic [2:0] cnt3(input logic [CW-1:0] n);
    cnt3 = (n > CW'(7)) ? 3'h7 : n[2:0];
  endfunction
  // Control and status state
  logic en_r, idle_stop_r, rov_r, enh_r, master_r, wide_r, busy_r;
  logic [2:0] sel_r, sck_s_r, sdi_s_r, ss_s_r;
  logic [3:0] ist_r, imask_r;
  logic [15:0] tx_mem [DEPTH];
  logic [15:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [CW-1:0] tx_cnt_r, rx_cnt_r;
  logic [15:0] sr_r;
  logic [4:0] bits_r;
  logic [7:0] div_r, awa_r;
  logic sck_out_r, sdo_r, ss_out_r;
  logic rx_3q_prev_r, rx_avail_prev_r, tx_full_prev_r, rx_full_prev_r;
  // Bus slave state
  logic aw_r, w_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  // Port gating: running when enabled and not halted by idle
  wire run = en_r && !(idle_stop_r && idle_i);
  wire [4:0] nbits = wide_r ? 5'd16 : 5'd8;
  function automatic logic depth_ok(input logic [CW-1:0] n);
    depth_ok = enh_r ? (n < CW'(DEPTH)) : (n == CW'(0));
  endfunction
  wire cap = depth_ok(rx_cnt_r);
  wire tx_full = enh_r ? (tx_cnt_r == CW'(DEPTH)) : (tx_cnt_r != CW'(0));
  wire rx_full = !depth_ok(rx_cnt_r);
  // Bus write decode
  wire wr_go = aw_r && w_r && !bvalid_o;
  wire wr_stat = wr_go && awa_r == ssc_pkg::SSC_OFF_STAT;
  wire wr_data = wr_go && awa_r == ssc_pkg::SSC_OFF_DATA;
  wire wr_cfg = wr_go && awa_r == ssc_pkg::SSC_OFF_CFG;
  wire wr_ist = wr_go && awa_r == ssc_pkg::SSC_OFF_IRQ_ST;
  wire wr_msk = wr_go && awa_r == ssc_pkg::SSC_OFF_IRQ_MASK;
  wire wr_ok = wr_stat | wr_data | wr_cfg | wr_ist | wr_msk;
  wire push_tx = wr_data && !tx_full && ws_r[0];
  wire rd_go = arvalid_i && arready_o;
  wire pop_rx = rd_go && araddr_i == ssc_pkg::SSC_OFF_DATA &&
    rx_cnt_r != CW'(0);
  // Serial clock edge detection from synchronised pins
  wire sck_rise = sck_s_r[1] && !sck_s_r[2];
  wire sck_fall = !sck_s_r[1] && sck_s_r[2];
  wire sl_sel = !ss_s_r[1];
  wire div_tick = div_r == 8'(CLK_DIV - 1);
  wire m_rise = master_r && busy_r && div_tick && !sck_out_r;
  wire m_fall = master_r && busy_r && div_tick && sck_out_r;
  wire smp = run && (master_r ? m_rise : (sl_sel && sck_rise));
  wire shf = run && (master_r ? m_fall : (sl_sel && sck_fall));
  wire load = run && !busy_r && tx_cnt_r != CW'(0) &&
    (master_r || sl_sel);
  wire done = smp && bits_r == nbits - 5'd1;
  wire [15:0] sr_in = {sr_r[14:0], master_r ? sdi_s_r[1] : sdi_s_r[1]};
  wire rx_store = done && cap;
  wire rx_drop = done && !cap;
  // Status word assembly
  wire [2:0] bec = enh_r ?
    (master_r ? cnt3(tx_cnt_r) : cnt3(rx_cnt_r)) : 3'h0;
  wire sr_empty = enh_r && !busy_r;
  wire rx_empty = enh_r && rx_cnt_r == CW'(0);
  wire [15:0] stat = {en_r, 1'b0, idle_stop_r, 2'b00, bec, sr_empty,
    rov_r, rx_empty, sel_r, tx_full, rx_full};
  // Buffer event selected by the mode field
  wire rx_3q = int'(rx_cnt_r) * 4 >= 3 * DEPTH; // Full int width, no wrap
  logic buf_lvl;
  always_comb
  begin
    case (ssc_pkg::ssc_sel_type'(sel_r))
      ssc_pkg::SSC_SEL_TX_FULL: buf_lvl = tx_full && !tx_full_prev_r;
      ssc_pkg::SSC_SEL_TX_EMPTY:
        buf_lvl = load && tx_cnt_r == CW'(1);
      ssc_pkg::SSC_SEL_TX_DONE: buf_lvl = done;
      ssc_pkg::SSC_SEL_TX_ONE_OPEN: buf_lvl = load && tx_full;
      ssc_pkg::SSC_SEL_RX_FULL: buf_lvl = rx_full && !rx_full_prev_r;
      ssc_pkg::SSC_SEL_RX_3Q: buf_lvl = rx_3q && !rx_3q_prev_r;
      ssc_pkg::SSC_SEL_RX_AVAIL:
        buf_lvl = rx_cnt_r != CW'(0) && !rx_avail_prev_r;
      ssc_pkg::SSC_SEL_RX_READ_EMPTY: buf_lvl = pop_rx &&
        rx_cnt_r == CW'(1);
      default: buf_lvl = 1'b0;
    endcase
  end
  wire [3:0] ev = {load, rx_store, rov_r ? 1'b0 : rx_drop,
    buf_lvl && run};
  // Read data mux
  logic [31:0] rd_val;
  logic rd_err;
  always_comb
  begin
    rd_err = 1'b0;
    case (araddr_i)
      ssc_pkg::SSC_OFF_STAT: rd_val = {16'h0000, stat};
      ssc_pkg::SSC_OFF_DATA: rd_val = {16'h0000, rx_mem[rx_rp_r]};
      ssc_pkg::SSC_OFF_CFG: rd_val = {29'h0, wide_r, master_r, enh_r};
      ssc_pkg::SSC_OFF_IRQ_ST: rd_val = {28'h0, ist_r};
      ssc_pkg::SSC_OFF_IRQ_MASK: rd_val = {28'h0, imask_r};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end
  // Pin synchronisers, two flops before use
  always_ff @(posedge clk_i)
  begin
    sck_s_r <= {sck_s_r[1:0], sck_i};
    sdi_s_r <= {sdi_s_r[1:0], sdi_i};
    ss_s_r <= {ss_s_r[1:0], ss_n_i};
  end

  // AXI4-Lite write channel
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= ssc_pkg::SSC_RESP_OKAY;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        aw_r <= 1'b1;
        awa_r <= awaddr_i;
      end
      if (wvalid_i && wready_o)
      begin
        w_r <= 1'b1;
        wd_r <= wdata_i;
        ws_r <= wstrb_i;
      end
      if (wr_go)
      begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok ? ssc_pkg::SSC_RESP_OKAY :
          ssc_pkg::SSC_RESP_SLVERR;
      end
      else if (bready_i)
        bvalid_o <= 1'b0;
    end
  end
  assign awready_o = !aw_r && !bvalid_o;
  assign wready_o = !w_r && !bvalid_o;

  // AXI4-Lite read channel, one cycle answer
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= ssc_pkg::SSC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_o <= 1'b1;
      rdata_o <= rd_val;
      rresp_o <= rd_err ? ssc_pkg::SSC_RESP_SLVERR :
        ssc_pkg::SSC_RESP_OKAY;
    end
    else if (rready_i)
      rvalid_o <= 1'b0;
  end
  assign arready_o = !rvalid_o;

  // Control bits, overflow flag and interrupt registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      en_r <= 1'b0;
      idle_stop_r <= 1'b0;
      sel_r <= 3'h0;
      rov_r <= 1'b0;
      enh_r <= 1'b0;
      master_r <= 1'b0;
      wide_r <= 1'b0;
      ist_r <= ssc_pkg::SSC_IRQ_RST;
      imask_r <= ssc_pkg::SSC_IRQ_RST;
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr_stat && ws_r[1])
      begin
        en_r <= wd_r[ssc_pkg::SSC_B_EN];
        idle_stop_r <= wd_r[ssc_pkg::SSC_B_IDLE_STOP];
      end
      if (wr_stat && ws_r[0])
        sel_r <= wd_r[ssc_pkg::SSC_B_IRQ_MODE_LO +: 3];
      // Overflow: hardware sets, software writes zero to clear
      if (rx_drop)
        rov_r <= 1'b1;
      else if (wr_stat && ws_r[0] && !wd_r[ssc_pkg::SSC_B_ROV])
        rov_r <= 1'b0;
      if (wr_cfg && ws_r[0])
      begin
        enh_r <= wd_r[ssc_pkg::SSC_B_ENH];
        master_r <= wd_r[ssc_pkg::SSC_B_MASTER];
        wide_r <= wd_r[ssc_pkg::SSC_B_WIDE];
      end
      // Sticky events, set wins over write-one-to-clear
      ist_r <= (ist_r & ~((wr_ist && ws_r[0]) ? wd_r[3:0] : 4'h0)) | ev;
      if (wr_msk && ws_r[0])
        imask_r <= wd_r[3:0];
      irq_o <= |(ist_r & imask_r);
    end
  end

  // Transmit and receive buffers with hardware full flags
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !en_r)
    begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end
    else
    begin
      if (push_tx)
      begin
        tx_mem[tx_wp_r] <= wd_r[15:0];
        tx_wp_r <= AW'((tx_wp_r + 1) % DEPTH);
      end
      if (load)
        tx_rp_r <= AW'((tx_rp_r + 1) % DEPTH);
      tx_cnt_r <= tx_cnt_r + CW'(push_tx) - CW'(load);
      if (rx_store)
      begin
        rx_mem[rx_wp_r] <= wide_r ? sr_in : {8'h00, sr_in[7:0]};
        rx_wp_r <= AW'((rx_wp_r + 1) % DEPTH);
      end
      if (pop_rx)
        rx_rp_r <= AW'((rx_rp_r + 1) % DEPTH);
      rx_cnt_r <= rx_cnt_r + CW'(rx_store) - CW'(pop_rx);
    end
  end

  // Shifter and master clock divider
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !en_r)
    begin
      busy_r <= 1'b0;
      bits_r <= 5'd0;
      sr_r <= 16'h0000;
      div_r <= 8'h00;
      sck_out_r <= 1'b0;
      sdo_r <= 1'b0;
      ss_out_r <= 1'b1;
    end
    else
    begin
      div_r <= (div_tick || !busy_r) ? 8'h00 : div_r + 8'h01;
      if (load)
      begin
        busy_r <= 1'b1;
        bits_r <= 5'd0;
        sr_r <= wide_r ? tx_mem[tx_rp_r] :
          {tx_mem[tx_rp_r][7:0], 8'h00};
        sdo_r <= wide_r ? tx_mem[tx_rp_r][15] : tx_mem[tx_rp_r][7];
        ss_out_r <= !master_r;
      end
      if (master_r && busy_r && div_tick)
        sck_out_r <= !sck_out_r;
      if (smp)
      begin
        sr_r <= sr_in;
        bits_r <= done ? 5'd0 : bits_r + 5'd1; // Restart after last bit
      end
      if (shf)
        sdo_r <= sr_r[15];
      // A slave frame cut short by deselect starts over
      if (!master_r && !sl_sel)
        bits_r <= 5'd0;
      if (done)
        busy_r <= 1'b0;
      if (done && master_r)
        ss_out_r <= 1'b1;
    end
  end

  // Pins driven only while the port is enabled
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pins_o <= '{sck: 1'b0, sdo: 1'b0, ss_n: 1'b1};
      pins_oe_o <= 1'b0;
    end
    else
    begin
      pins_o <= '{sck: sck_out_r, sdo: sdo_r, ss_n: ss_out_r};
      pins_oe_o <= en_r;
    end
  end

  // Edge history; follows reset levels so no false edge after reset
  always_ff @(posedge clk_i)
  begin
    rx_3q_prev_r <= rx_3q;
    rx_avail_prev_r <= rx_cnt_r != CW'(0);
    tx_full_prev_r <= tx_full;
    rx_full_prev_r <= rx_full;
  end
endmodule

// [ssc_pkg.sv]
// Package for the serial port status and control block
package ssc_pkg;
  // Register byte offsets
  localparam logic [7:0] SSC_OFF_STAT = 8'h00;
  localparam logic [7:0] SSC_OFF_DATA = 8'h04;
  localparam logic [7:0] SSC_OFF_CFG = 8'h08;
  localparam logic [7:0] SSC_OFF_IRQ_ST = 8'h0C;
  localparam logic [7:0] SSC_OFF_IRQ_MASK = 8'h10;
  // Status and control field positions
  localparam int SSC_B_EN = 15;
  localparam int SSC_B_IDLE_STOP = 13;
  localparam int SSC_B_BEC_LO = 8;
  localparam int SSC_B_SR_EMPTY = 7;
  localparam int SSC_B_ROV = 6;
  localparam int SSC_B_RX_EMPTY = 5;
  localparam int SSC_B_IRQ_MODE_LO = 2;
  localparam int SSC_B_TBF = 1;
  localparam int SSC_B_RBF = 0;
  // Configuration register field positions
  localparam int SSC_B_ENH = 0;
  localparam int SSC_B_MASTER = 1;
  localparam int SSC_B_WIDE = 2;
  // Reset values
  localparam logic [15:0] SSC_STAT_RST = 16'h0000;
  localparam logic [3:0] SSC_IRQ_RST = 4'h0;
  // Interrupt status bits
  localparam int SSC_I_BUF = 0;
  localparam int SSC_I_ROV = 1;
  localparam int SSC_I_RX = 2;
  localparam int SSC_I_TX = 3;
  // Bus responses
  localparam logic [1:0] SSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSC_RESP_SLVERR = 2'h2;
  // Buffer interrupt modes
  typedef enum logic [2:0] {
    SSC_SEL_RX_READ_EMPTY = 3'h0,
    SSC_SEL_RX_AVAIL = 3'h1,
    SSC_SEL_RX_3Q = 3'h2,
    SSC_SEL_RX_FULL = 3'h3,
    SSC_SEL_TX_ONE_OPEN = 3'h4,
    SSC_SEL_TX_DONE = 3'h5,
    SSC_SEL_TX_EMPTY = 3'h6,
    SSC_SEL_TX_FULL = 3'h7
  } ssc_sel_type;
  // Serial pin group
  typedef struct packed {
    logic sck;
    logic sdo;
    logic ss_n;
  } ssc_pins_type;
endpackage

// [ssc_top_checker.sv]
// Assertion checker for the serial port status and control block
`timescale 1ns/100ps
module ssc_top_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic [1:0] bresp_o,
  input wire logic bvalid_o,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] rresp_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic pins_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] ar_r;
  logic [7:0] aw_r;
  logic enh_r;
  // Remember the last taken addresses and the enhanced mode setting
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ar_r <= 8'h00;
      aw_r <= 8'h00;
      enh_r <= 1'b0;
    end
    else
    begin
      if (arvalid_i && arready_o) ar_r <= araddr_i;
      if (awvalid_i && awready_o) aw_r <= awaddr_i;
      if (awvalid_i && awready_o && wvalid_i && wready_o && awaddr_i == 8'h08)
        enh_r <= wdata_i[0];
    end
  end
  // Address decode of the remembered accesses
  wire stat_rd = ar_r == 8'h00;
  wire ar_bad = ar_r > 8'h10;
  wire aw_bad = aw_r > 8'h10;
  a_rd_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
    else $error("read not answered next cycle");
  a_rd_hold: assert property (rvalid_o && !rready_i |=>
    rvalid_o && $stable(rdata_o)) else $error("read data not held");
  a_wr_answer: assert property (awvalid_i && awready_o && wvalid_i &&
    wready_o |-> ##[1:2] bvalid_o) else $error("write not answered");
  a_bad_wr: assert property (bvalid_o && aw_bad |-> bresp_o == 2'h2)
    else $error("unmapped write not refused");
  a_bad_rd: assert property (rvalid_o && ar_bad |-> rresp_o == 2'h2)
    else $error("unmapped read not refused");
  a_unimpl_zero: assert property (
    rvalid_o && stat_rd |-> !rdata_o[14] && rdata_o[12:11] == 2'h0)
    else $error("unimplemented status bits not zero");
  a_en_oe: assert property (
    rvalid_o && stat_rd |-> rdata_o[15] == pins_oe_o)
    else $error("pin takeover differs from enable bit");
  a_oe_by_write: assert property (
    $changed(pins_oe_o) |-> $past(bvalid_o) or ##[0:2] bvalid_o)
    else $error("pin takeover changed without a write");
  a_irq_drop: assert property ($fell(irq_o) |->
    bvalid_o || $past(bvalid_o) || $past(bvalid_o, 2))
    else $error("interrupt dropped without a write");
  a_plain_zero: assert property (
    rvalid_o && stat_rd && !enh_r |-> rdata_o[10:7] == 4'h0 && !rdata_o[5])
    else $error("enhanced flags set outside enhanced mode");
endmodule
bind ssc_top ssc_top_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
  .wdata_i(wdata_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
  .bresp_o(bresp_o), .bvalid_o(bvalid_o), .araddr_i(araddr_i),
  .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
  .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
  .pins_oe_o(pins_oe_o), .irq_o(irq_o));

// [ssc_spi_master_model.sv]
// Behavioural serial master that clocks bytes into the slave port
`timescale 1ns/100ps
module ssc_spi_master_model (
  output logic sck_o,
  output logic sdi_o,
  output logic ss_n_o
);
  // Idle: clock low and still, select released
  initial
  begin
    sck_o = 1'b0;
    sdi_o = 1'b1;
    ss_n_o = 1'b1;
  end
  // Sends one byte MSB first at an 800 ns clock period
  task automatic send(input logic [7:0] b);
    int i;
    #20;  // Keep pin changes off the sampling clock edges
    ss_n_o = 1'b0;
    for (i = 7; i >= 0; i--)
    begin
      sdi_o = b[i];
      #400 sck_o = 1'b1;
      #400 sck_o = 1'b0;
    end
    #400 ss_n_o = 1'b1;
    sdi_o = ~b[0];  // Released line must not show the last bit
  endtask
endmodule

// [test_spi_status_control.sv]
// Self-checking bench for the serial port status and control block
`timescale 1ns/100ps
module test_spi_status_control;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic idle_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00;
  logic [7:0] araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] wstrb_i = 4'hF;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
  logic arvalid_i = 1'b0, rready_i = 1'b0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic pins_oe_o, irq_o, sck_i, sdi_i, ss_n_i;
  logic [1:0] bresp_o, rresp_o, rsp;
  logic [31:0] rdata_o, rd_d;
  ssc_pkg::ssc_pins_type pins_o;
  int fail_count = 0;
  int n_tests = 0;
  int i;
  ssc_top #(.DEPTH(8), .CLK_DIV(4)) dut (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .idle_i(idle_i), .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready_i), .sck_i(sck_i), .sdi_i(sdi_i), .ss_n_i(ss_n_i),
    .pins_o(pins_o), .pins_oe_o(pins_oe_o), .irq_o(irq_o));
  ssc_spi_master_model spi (.sck_o(sck_i), .sdi_o(sdi_i), .ss_n_o(ss_n_i));
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  // Compares one value and reports a difference
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus write: address and data offered together, waits for response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do
    begin
      @(negedge clk_i);
      ah = awvalid_i && awready_o;
      wh = wvalid_i && wready_o;
      bh = bvalid_o;
      rsp = bresp_o;
      @(posedge clk_i);
      if (ah) awvalid_i <= 1'b0;
      if (wh) wvalid_i <= 1'b0;
    end
    while (!bh);
    bready_i <= 1'b0;
  endtask
  // Bus read: result left in rd_d and rsp
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do
    begin
      @(negedge clk_i);
      ah = arvalid_i && arready_o;
      rh = rvalid_o;
      rd_d = rdata_o;
      rsp = rresp_o;
      @(posedge clk_i);
      if (ah) arvalid_i <= 1'b0;
    end
    while (!rh);
    rready_i <= 1'b0;
  endtask
  // Read and compare under a mask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    rd(a);
    chk(rd_d & m, e);
  endtask
  // Serial byte in, then time for the input synchronisers
  task automatic rx(input logic [7:0] b);
    spi.send(b);
    repeat (6) @(posedge clk_i);
  endtask
  // Prints the verdict and ends the run
  task automatic close_out;
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #600000;
    fail_count++;
    close_out();
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rc(8'h00, 32'hFFFF, 32'h0000);
    wr(8'h00, 32'hFFFF);
    rc(8'h00, 32'hFFFF, 32'hA01C);
    chk(32'(pins_oe_o), 32'h1);
    for (i = 0; i < 8; i++)
    begin
      wr(8'h00, 32'h8000 | 32'(i << 2));
      rc(8'h00, 32'h001C, 32'(i << 2));
    end
    wr(8'h00, 32'h8000);
    wr(8'h10, 32'h2);
    rx(8'hA5);
    rc(8'h00, 32'hFFFF, 32'h8001);
    rx(8'h3C);
    rc(8'h00, 32'hFFFF, 32'h8041);
    chk(32'(irq_o), 32'h1);
    rc(8'h04, 32'hFF, 32'hA5);
    rc(8'h00, 32'hFFFF, 32'h8040);
    wr(8'h00, 32'h8040);
    rc(8'h00, 32'hFFFF, 32'h8040);
    wr(8'h00, 32'h8000);
    rc(8'h00, 32'hFFFF, 32'h8000);
    wr(8'h0C, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    wr(8'h08, 32'h1);
    rx(8'h11);
    rx(8'h22);
    rc(8'h00, 32'h07A1, 32'h0280);
    rc(8'h04, 32'hFF, 32'h11);
    rc(8'h04, 32'hFF, 32'h22);
    rc(8'h00, 32'h07A1, 32'h00A0);
    wr(8'h00, 32'hA000);
    idle_i <= 1'b1;
    rx(8'h33);
    rc(8'h00, 32'h0721, 32'h0020);
    idle_i <= 1'b0;
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h55);
    wr(8'h04, 32'hAA);
    rc(8'h00, 32'h0780, 32'h0100);
    chk(32'(pins_o.ss_n), 32'h0);
    repeat (200) @(posedge clk_i);
    rc(8'h00, 32'h0780, 32'h0080);
    wr(8'h14, 32'h1);
    chk(32'(rsp), 32'h2);
    rd(8'h14);
    chk(32'(rsp), 32'h2);
    wr(8'h00, 32'h0);
    @(negedge clk_i);
    chk(32'(pins_oe_o), 32'h0);
    close_out();
  end
endmodule
